// ### hrs_axis_model.sv
// Axis, proximity switch and encoder index model for the home return sequencer
`timescale 1ns/1ps
module hrs_axis_model #(
    parameter int START_POS = 1000,
    parameter int SW_LO = 1020,
    parameter int SW_HI = 1040,
    parameter int IDX_PER = 16,
    parameter int STOP_POS = 1010,
    parameter int STEP_GAP = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic dir,
    input wire logic pol,
    output logic step,
    output logic fdir,
    output logic prox,
    output logic index,
    output logic stop,
    output int pos
);
    int gap;
    logic det;

    // Wide step spacing keeps a step from landing inside the sensor latency
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos <= START_POS;
            gap <= 0;
            step <= 1'b0;
            fdir <= 1'b0;
        end else begin
            step <= 1'b0;
            if (run && gap == STEP_GAP - 1) begin
                gap <= 0;
                step <= 1'b1;
                fdir <= dir;
                pos <= dir ? pos - 1 : pos + 1;
            end else begin
                gap <= run ? gap + 1 : 0;
            end
        end
    end

    assign det = (pos >= SW_LO) && (pos <= SW_HI);
    assign prox = pol ? det : !det;
    // Index stays high for the whole step period, well above two clocks
    assign index = (pos % IDX_PER) == 0;
    assign stop = pos >= STOP_POS;
endmodule

// ### hrs_dist_counter.sv
// Step counter that flags when a loaded travel distance has been covered
`timescale 1ns/1ps
module hrs_dist_counter #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [W-1:0] target,
    input wire logic step,
    output logic done
);
    localparam logic [W-1:0] ONE = W'(1);
    localparam logic [W-1:0] ZERO = W'(0);
    logic [W-1:0] remaining;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            remaining <= ZERO;
            done <= 1'b1;
        end else if (load) begin
            remaining <= target;
            done <= (target == ZERO);
        end else if (step && !done) begin
            remaining <= remaining - ONE;
            done <= (remaining == ONE);
        end
    end
endmodule

// ### hrs_home_sequencer.sv
// Home position return sequencer: method selection, approach, creep, shift and load
// Function
// - Method setting picks one of eleven homing methods, codes 0 to A.
// - Direction 0 starts toward increasing addresses, 1 toward decreasing.
// - Polarity 0 means switch off detects, 1 means switch on detects.
// - Switch method: slow at front edge, home at first index past rear edge plus shift.
// - Homing speed until switch detected, creep speed afterwards; stopper and switchless run at creep speed throughout.
// - Switch method measures shift from first index after the rear edge.
// - Acceleration and deceleration constants come from position table entry one.
// - Completion loads the current position with the home position value.
// - Count front-end: slow at front edge, home after post distance plus shift.
// - Cradle: home at first index after switch front edge.
// - First-index: reverse after front edge, home at first index plus shift.
// - Front-end: switch front edge itself is home, no index used.
// - Switchless: ignore switch, home at first index plus shift.
`timescale 1ns/1ps
module hrs_home_sequencer #(
    parameter int POS_W = 32,
    parameter int SPEED_W = 16,
    parameter int TIME_W = 16
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic START,
    input wire logic ABORT,
    input wire logic TWO_STATION_MODE,
    input wire logic AUTO_MANUAL_SELECT_IN,
    input wire logic [hrs_pkg::TABLE_LOW_W-1:0] TABLE_SELECT_BITS_LOW,
    input wire logic [hrs_pkg::TABLE_HIGH_W-1:0] TABLE_SELECT_BITS_HIGH,
    input wire logic REMOTE_POS_SPEED_SELECT,
    input wire logic [hrs_pkg::METHOD_W-1:0] HOMING_METHOD_PARAM,
    input wire logic HOMING_DIRECTION_PARAM,
    input wire logic INPUT_POLARITY_PARAM,
    input wire logic [SPEED_W-1:0] HOMING_SPEED_PARAM,
    input wire logic [SPEED_W-1:0] CREEP_SPEED_PARAM,
    input wire logic [POS_W-1:0] HOME_SHIFT_DISTANCE_PARAM,
    input wire logic [POS_W-1:0] HOME_POSITION_VALUE_PARAM,
    input wire logic [POS_W-1:0] POST_SWITCH_DISTANCE_PARAM,
    input wire logic [TIME_W-1:0] TABLE1_ACCEL_TIME,
    input wire logic [TIME_W-1:0] TABLE1_DECEL_TIME,
    input wire logic PROX_SWITCH_IN,
    input wire logic INDEX_PULSE_IN,
    input wire logic STOPPER_REACHED_IN,
    input wire logic FEEDBACK_STEP,
    input wire logic FEEDBACK_DIR,
    output logic CMD_RUN,
    output logic CMD_DIR,
    output logic [SPEED_W-1:0] CMD_SPEED,
    output logic [TIME_W-1:0] CMD_ACCEL_TIME,
    output logic [TIME_W-1:0] CMD_DECEL_TIME,
    output logic [POS_W-1:0] CURRENT_POSITION,
    output logic HOMING_BUSY,
    output logic HOMING_DONE,
    output logic HOMING_ERROR
);
    import hrs_pkg::*;

    localparam logic [POS_W-1:0] POS_ONE = POS_W'(1);

    hrs_state_t state;
    hrs_state_t next_state;
    logic [METHOD_W-1:0] method;
    logic run_dir;
    logic next_run_dir;
    logic sw_rise;
    logic sw_fall;
    logic idx_rise;
    logic sw_front;
    logic sw_rear;
    logic request_ok;
    logic start_ok;
    logic start_bad;
    logic dist_load;
    logic [POS_W-1:0] dist_target;
    logic dist_done;
    logic next_motion;

    // Raw pin edges, resolved against polarity below
    hrs_sync_edge u_sw_sync (
        .clk(MCLK), .rst_n(NRST), .din(PROX_SWITCH_IN),
        .level(), .rise(sw_rise), .fall(sw_fall)
    );
    hrs_sync_edge u_idx_sync (
        .clk(MCLK), .rst_n(NRST), .din(INDEX_PULSE_IN),
        .level(), .rise(idx_rise), .fall()
    );

    // Detection starts on the edge that enters the active level
    assign sw_front = (INPUT_POLARITY_PARAM == POL_ON_DETECTS) ? sw_rise : sw_fall;
    assign sw_rear = (INPUT_POLARITY_PARAM == POL_ON_DETECTS) ? sw_fall : sw_rise;

    // Start is only honoured when the host has put the drive in manual homing mode
    assign request_ok = AUTO_MANUAL_SELECT_IN && (TABLE_SELECT_BITS_LOW == TABLE_LOW_OFF)
        && (TABLE_SELECT_BITS_HIGH == TABLE_HIGH_OFF)
        && (!TWO_STATION_MODE || REMOTE_POS_SPEED_SELECT);
    assign start_ok = START && request_ok && (HOMING_METHOD_PARAM <= METHOD_LAST);
    assign start_bad = START && request_ok && (HOMING_METHOD_PARAM > METHOD_LAST);

    always_comb begin
        next_state = state;
        next_run_dir = run_dir;
        if (ABORT) begin
            next_state = ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (start_ok) begin
                        next_run_dir = HOMING_DIRECTION_PARAM;
                        unique case (HOMING_METHOD_PARAM)
                            M_DATA_SET, M_SERVO_ON: next_state = ST_LOAD;
                            M_STOPPER: next_state = ST_STOPPER;
                            M_SWITCHLESS: next_state = ST_INDEX;
                            default: next_state = ST_FAST;
                        endcase
                    end
                end
                ST_FAST: begin
                    if (sw_front) begin
                        unique case (method)
                            M_DOG, M_REAR_END: next_state = ST_CREEP_REAR;
                            M_COUNT, M_COUNT_FRONT: next_state = ST_POST;
                            M_CRADLE: next_state = ST_INDEX;
                            M_FIRST_INDEX: begin
                                next_state = ST_INDEX;
                                next_run_dir = ~run_dir;
                            end
                            M_FRONT_END: next_state = ST_LOAD;
                            default: next_state = ST_IDLE;
                        endcase
                    end
                end
                ST_CREEP_REAR: begin
                    if (sw_rear) begin
                        next_state = (method == M_REAR_END) ? ST_POST : ST_INDEX;
                    end
                end
                ST_POST: begin
                    if (dist_done) begin
                        next_state = (method == M_COUNT) ? ST_INDEX : ST_SHIFT;
                    end
                end
                ST_INDEX: begin
                    // Switch is not looked at here, so switchless homing ignores it
                    if (idx_rise) begin
                        next_state = (method == M_CRADLE) ? ST_LOAD : ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (dist_done) begin
                        next_state = ST_LOAD;
                    end
                end
                ST_STOPPER: begin
                    if (STOPPER_REACHED_IN) begin
                        next_state = ST_LOAD;
                    end
                end
                ST_LOAD: next_state = ST_IDLE;
                default: next_state = ST_IDLE;
            endcase
        end
    end

    // Distance counter is reloaded on entry to each measured leg
    assign dist_load = (next_state != state) && ((next_state == ST_POST)
        || (next_state == ST_SHIFT));
    assign dist_target = (next_state == ST_POST) ? POST_SWITCH_DISTANCE_PARAM
        : HOME_SHIFT_DISTANCE_PARAM;
    assign next_motion = (next_state != ST_IDLE) && (next_state != ST_LOAD);

    hrs_dist_counter #(.W(POS_W)) u_dist (
        .clk(MCLK), .rst_n(NRST), .load(dist_load), .target(dist_target),
        .step(FEEDBACK_STEP), .done(dist_done)
    );

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            state <= ST_IDLE;
            run_dir <= DIR_INCREASE;
        end else begin
            state <= next_state;
            run_dir <= next_run_dir;
        end
    end

    // Method is latched so a parameter change mid-run cannot switch the sequence
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            method <= M_DOG;
        end else if (state == ST_IDLE && start_ok) begin
            method <= HOMING_METHOD_PARAM;
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            CMD_RUN <= 1'b0;
            CMD_DIR <= DIR_INCREASE;
            CMD_SPEED <= SPEED_RESET;
        end else begin
            CMD_RUN <= next_motion;
            CMD_DIR <= next_run_dir;
            if (!next_motion) begin
                CMD_SPEED <= SPEED_RESET;
            end else if (next_state == ST_FAST) begin
                CMD_SPEED <= HOMING_SPEED_PARAM;
            end else begin
                CMD_SPEED <= CREEP_SPEED_PARAM;
            end
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            CMD_ACCEL_TIME <= TIME_RESET;
            CMD_DECEL_TIME <= TIME_RESET;
        end else begin
            CMD_ACCEL_TIME <= TABLE1_ACCEL_TIME;
            CMD_DECEL_TIME <= TABLE1_DECEL_TIME;
        end
    end

    // Load wins over a step arriving in the same cycle
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            CURRENT_POSITION <= POS_RESET;
        end else if (state == ST_LOAD) begin
            CURRENT_POSITION <= HOME_POSITION_VALUE_PARAM;
        end else if (FEEDBACK_STEP) begin
            if (FEEDBACK_DIR == DIR_INCREASE) begin
                CURRENT_POSITION <= CURRENT_POSITION + POS_ONE;
            end else begin
                CURRENT_POSITION <= CURRENT_POSITION - POS_ONE;
            end
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            HOMING_BUSY <= 1'b0;
            HOMING_DONE <= 1'b0;
            HOMING_ERROR <= 1'b0;
        end else begin
            HOMING_BUSY <= (next_state != ST_IDLE);
            if (state == ST_LOAD) begin
                HOMING_DONE <= 1'b1;
            end else if (start_ok || ABORT) begin
                HOMING_DONE <= 1'b0;
            end
            if (start_bad) begin
                HOMING_ERROR <= 1'b1;
            end else if (start_ok) begin
                HOMING_ERROR <= 1'b0;
            end
        end
    end

    property p_load_position;
        @(posedge MCLK) disable iff (!NRST)
        (state == ST_LOAD) |=> (CURRENT_POSITION == $past(HOME_POSITION_VALUE_PARAM));
    endproperty
    a_load_position: assert property (p_load_position)
        else $error("Position not loaded with home value");
    property p_done_after_load;
        @(posedge MCLK) disable iff (!NRST)
        (state == ST_LOAD) |=> (HOMING_DONE && !HOMING_BUSY && state == ST_IDLE);
    endproperty
    a_done_after_load: assert property (p_done_after_load)
        else $error("Done status missing after load");
    property p_fast_speed;
        @(posedge MCLK) disable iff (!NRST)
        (state == ST_FAST && $past(state) == ST_FAST)
            |-> (CMD_RUN && CMD_SPEED == $past(HOMING_SPEED_PARAM));
    endproperty
    a_fast_speed: assert property (p_fast_speed)
        else $error("Approach not at homing speed");
    property p_creep_speed;
        @(posedge MCLK) disable iff (!NRST)
        (state inside {ST_CREEP_REAR, ST_POST, ST_SHIFT} && $past(state) == state)
            |-> (CMD_SPEED == $past(CREEP_SPEED_PARAM));
    endproperty
    a_creep_speed: assert property (p_creep_speed)
        else $error("Post-detection travel not at creep speed");
    property p_start_dir;
        @(posedge MCLK) disable iff (!NRST)
        (state == ST_IDLE && start_ok && !ABORT)
            |=> (CMD_DIR == $past(HOMING_DIRECTION_PARAM));
    endproperty
    a_start_dir: assert property (p_start_dir)
        else $error("Start direction differs from setting");
    property p_front_end_home;
        @(posedge MCLK) disable iff (!NRST)
        (state == ST_FAST && sw_front && method == M_FRONT_END && !ABORT)
            |=> (state == ST_LOAD) ##1 HOMING_DONE;
    endproperty
    a_front_end_home: assert property (p_front_end_home)
        else $error("Front edge did not become home");
    property p_reverse;
        @(posedge MCLK) disable iff (!NRST)
        (state == ST_FAST && sw_front && method == M_FIRST_INDEX && !ABORT)
            |=> (state == ST_INDEX && CMD_DIR != $past(CMD_DIR));
    endproperty
    a_reverse: assert property (p_reverse)
        else $error("No reversal after front edge");
    property p_cradle;
        @(posedge MCLK) disable iff (!NRST)
        (state == ST_INDEX && idx_rise && method == M_CRADLE && !ABORT) |=> (state == ST_LOAD);
    endproperty
    a_cradle: assert property (p_cradle)
        else $error("Cradle index did not set home");
    property p_accel;
        @(posedge MCLK) disable iff (!NRST)
        $rose(CMD_RUN) |-> (CMD_ACCEL_TIME == $past(TABLE1_ACCEL_TIME)
            && CMD_DECEL_TIME == $past(TABLE1_DECEL_TIME));
    endproperty
    a_accel: assert property (p_accel)
        else $error("Time constants not from table entry one");
    property p_switchless;
        @(posedge MCLK) disable iff (!NRST)
        (state == ST_IDLE && start_ok && !ABORT && HOMING_METHOD_PARAM == M_SWITCHLESS)
            |=> (state == ST_INDEX);
    endproperty
    a_switchless: assert property (p_switchless)
        else $error("Switchless homing did not go to index search");
    property p_gate;
        @(posedge MCLK) disable iff (!NRST)
        (state == ST_IDLE && !request_ok) |=> (state == ST_IDLE);
    endproperty
    a_gate: assert property (p_gate)
        else $error("Homing started outside manual mode");
endmodule

// ### hrs_home_sequencer_bench.sv
// Self-checking bench for the home return sequencer
`timescale 1ns/1ps
module hrs_home_sequencer_bench;
    import hrs_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic start = 1'b0;
    logic abort = 1'b0;
    logic two = 1'b0;
    logic am = 1'b1;
    logic rsel = 1'b0;
    logic dirp = 1'b0;
    logic pol = 1'b1;
    logic [4:0] tlo = 5'h00;
    logic [2:0] thi = 3'h0;
    logic [3:0] meth = 4'h0;
    logic [15:0] hspd = 16'h0040;
    logic [15:0] cspd = 16'h0008;
    logic [31:0] shift = 32'h0;
    logic [31:0] home = 32'h0;
    logic [31:0] post = 32'h0;
    logic [15:0] acc = 16'h0123;
    logic [15:0] dec = 16'h0456;
    logic prox, index, stop, step, fdir;
    logic run, cdir, busy, done, err;
    logic [15:0] speed, cacc, cdec;
    logic [31:0] cpos;
    int axis_pos;
    int n_mismatch = 0;
    int num_checks = 0;

    always #2 mclk = ~mclk;

    hrs_home_sequencer u_dut (
        .MCLK(mclk), .NRST(nrst), .START(start), .ABORT(abort),
        .TWO_STATION_MODE(two), .AUTO_MANUAL_SELECT_IN(am),
        .TABLE_SELECT_BITS_LOW(tlo), .TABLE_SELECT_BITS_HIGH(thi),
        .REMOTE_POS_SPEED_SELECT(rsel), .HOMING_METHOD_PARAM(meth),
        .HOMING_DIRECTION_PARAM(dirp), .INPUT_POLARITY_PARAM(pol),
        .HOMING_SPEED_PARAM(hspd), .CREEP_SPEED_PARAM(cspd),
        .HOME_SHIFT_DISTANCE_PARAM(shift), .HOME_POSITION_VALUE_PARAM(home),
        .POST_SWITCH_DISTANCE_PARAM(post), .TABLE1_ACCEL_TIME(acc),
        .TABLE1_DECEL_TIME(dec), .PROX_SWITCH_IN(prox), .INDEX_PULSE_IN(index),
        .STOPPER_REACHED_IN(stop), .FEEDBACK_STEP(step), .FEEDBACK_DIR(fdir),
        .CMD_RUN(run), .CMD_DIR(cdir), .CMD_SPEED(speed), .CMD_ACCEL_TIME(cacc),
        .CMD_DECEL_TIME(cdec), .CURRENT_POSITION(cpos), .HOMING_BUSY(busy),
        .HOMING_DONE(done), .HOMING_ERROR(err)
    );

    hrs_axis_model u_axis (
        .clk(mclk), .rst_n(nrst), .run(run), .dir(cdir), .pol(pol),
        .step(step), .fdir(fdir), .prox(prox), .index(index), .stop(stop),
        .pos(axis_pos)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic do_reset;
        @(posedge mclk);
        nrst <= 1'b0;
        start <= 1'b0;
        abort <= 1'b0;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
    endtask

    task automatic pulse_start;
        @(posedge mclk);
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
    endtask

    // Start must be ignored; status never shows busy
    task automatic refused(input logic a, input logic [4:0] lo, input logic [2:0] hi,
                           input logic tw, input logic rs, input logic [3:0] m);
        @(posedge mclk);
        am <= a;
        tlo <= lo;
        thi <= hi;
        two <= tw;
        rsel <= rs;
        meth <= m;
        pulse_start;
        repeat (4) begin
            @(negedge mclk);
            check(busy, 1'b0, "busy on refused start");
        end
        $display("test refused %h done", m);
    endtask

    task automatic run_case(input logic [3:0] m, input logic d, input logic p,
                            input logic [31:0] sh, input logic [31:0] ps, input int ex);
        int i;
        logic crept;
        @(posedge mclk);
        meth <= m;
        dirp <= d;
        pol <= p;
        shift <= sh;
        post <= ps;
        home <= 32'h0000_0100 + m;
        do_reset;
        pulse_start;
        crept = 1'b0;
        for (i = 0; i < 8 && busy !== 1'b1 && done !== 1'b1; i++) @(negedge mclk);
        if (m != 4'h2 && m != 4'h4) begin
            check(run, 1'b1, "run after start");
            check(cdir, d, "start direction");
            check(speed, (m == 4'h3 || m == 4'ha) ? cspd : hspd, "start speed");
            check(cacc, acc, "accel time");
            check(cdec, dec, "decel time");
        end
        for (i = 0; i < 6000 && done !== 1'b1; i++) begin
            @(negedge mclk);
            if (axis_pos == 1030 && !crept && done !== 1'b1) begin
                crept = 1'b1;
                check(speed, cspd, "creep inside switch");
            end
        end
        if (done !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t homing never completed", $time);
            conclude;
        end
        check(cpos, 32'h0000_0100 + m, "loaded position");
        check(busy, 1'b0, "busy after done");
        check(speed, 16'h0000, "speed after done");
        check(axis_pos, ex, "axis position at home");
        $display("test method %h done", m);
    endtask

    // Switch spans 1020..1040, index every 16 counts, stopper at 1010, start at 1000
    initial begin
        do_reset;
        refused(1'b0, 5'h00, 3'h0, 1'b0, 1'b0, 4'h0);
        refused(1'b1, 5'h01, 3'h0, 1'b0, 1'b0, 4'h0);
        refused(1'b1, 5'h00, 3'h4, 1'b0, 1'b0, 4'h0);
        refused(1'b1, 5'h00, 3'h0, 1'b1, 1'b0, 4'h0);
        refused(1'b1, 5'h00, 3'h0, 1'b1, 1'b1, 4'hb);
        check(err, 1'b1, "illegal method error");
        @(posedge mclk);
        meth <= 4'h2;
        pulse_start;
        repeat (4) @(negedge mclk);
        check(err, 1'b0, "error cleared by legal start");
        check(done, 1'b1, "data setting done");
        $display("test error recovery done");
        run_case(4'h0, 1'b0, 1'b1, 32'd5, 32'd0, 1061);
        run_case(4'h1, 1'b0, 1'b1, 32'd2, 32'd7, 1042);
        run_case(4'h2, 1'b0, 1'b1, 32'd0, 32'd0, 1000);
        run_case(4'h3, 1'b0, 1'b1, 32'd0, 32'd0, 1010);
        run_case(4'h4, 1'b0, 1'b1, 32'd0, 32'd0, 1000);
        run_case(4'h5, 1'b0, 1'b1, 32'd2, 32'd7, 1050);
        run_case(4'h6, 1'b0, 1'b1, 32'd2, 32'd7, 1029);
        run_case(4'h7, 1'b0, 1'b1, 32'd0, 32'd0, 1024);
        run_case(4'h8, 1'b0, 1'b1, 32'd2, 32'd0, 1006);
        run_case(4'h9, 1'b0, 1'b0, 32'd0, 32'd0, 1020);
        run_case(4'ha, 1'b1, 1'b1, 32'd3, 32'd0, 989);
        @(posedge mclk);
        meth <= 4'h0;
        abort <= 1'b1;
        @(posedge mclk);
        abort <= 1'b0;
        @(negedge mclk);
        check(done, 1'b0, "done cleared by abort");
        do_reset;
        pulse_start;
        repeat (20) @(posedge mclk);
        abort <= 1'b1;
        repeat (3) @(negedge mclk);
        check(busy, 1'b0, "busy after abort");
        check(run, 1'b0, "run after abort");
        check(done, 1'b0, "done after abort");
        @(posedge mclk);
        abort <= 1'b0;
        $display("test abort done");
        conclude;
    end
endmodule

// ### hrs_pkg.sv
// Shared constants, method codes and state encoding for the home return sequencer
package hrs_pkg;

    localparam int METHOD_W = 4;
    localparam int SPEED_W = 16;
    localparam int POS_W = 32;
    localparam int TIME_W = 16;
    localparam int TABLE_LOW_W = 5;
    localparam int TABLE_HIGH_W = 3;

    typedef enum logic [METHOD_W-1:0] {
        M_DOG = 4'h0,
        M_COUNT = 4'h1,
        M_DATA_SET = 4'h2,
        M_STOPPER = 4'h3,
        M_SERVO_ON = 4'h4,
        M_REAR_END = 4'h5,
        M_COUNT_FRONT = 4'h6,
        M_CRADLE = 4'h7,
        M_FIRST_INDEX = 4'h8,
        M_FRONT_END = 4'h9,
        M_SWITCHLESS = 4'ha
    } hrs_method_t;

    localparam logic [METHOD_W-1:0] METHOD_LAST = 4'ha;

    localparam logic DIR_INCREASE = 1'b0;
    localparam logic DIR_DECREASE = 1'b1;
    localparam logic POL_OFF_DETECTS = 1'b0;
    localparam logic POL_ON_DETECTS = 1'b1;

    localparam logic [SPEED_W-1:0] SPEED_RESET = 16'h0000;
    localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;
    localparam logic [TIME_W-1:0] TIME_RESET = 16'h0000;
    localparam logic [TABLE_LOW_W-1:0] TABLE_LOW_OFF = 5'h00;
    localparam logic [TABLE_HIGH_W-1:0] TABLE_HIGH_OFF = 3'h0;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_FAST = 4'h1,
        ST_CREEP_REAR = 4'h2,
        ST_POST = 4'h3,
        ST_INDEX = 4'h4,
        ST_SHIFT = 4'h5,
        ST_STOPPER = 4'h6,
        ST_LOAD = 4'h7
    } hrs_state_t;

endpackage

// ### hrs_sync_edge.sv
// Two-stage synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
module hrs_sync_edge (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic level,
    output logic rise,
    output logic fall
);
    localparam int WARM_W = 3;
    logic meta;
    logic held;
    logic [WARM_W-1:0] warm;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            level <= 1'b0;
            held <= 1'b0;
            warm <= {WARM_W{1'b0}};
        end else begin
            meta <= din;
            level <= meta;
            held <= level;
            warm <= {warm[WARM_W-2:0], 1'b1};
        end
    end

    // Edges wait until level and held both hold real pin samples, so a pin idling high
    // is not seen as a fresh edge after reset; an edge in those cycles is lost
    assign rise = level & ~held & warm[WARM_W-1];
    assign fall = ~level & held & warm[WARM_W-1];
endmodule
